// file: evc_checker_props.sv
`timescale 1ns/1ps
`include "evc_map.svh"
module evc_checker import evc_pkg::*; (
	input wire logic clk, rst, hard_reset, soft_reset, bus_transfer_error_n, machine_check_pin_n,
	input wire logic addr_parity_err, data_parity_err, icache_parity_err, dcache_parity_err,
	input wire evc_data_fault_s data_fault,
	input wire evc_fetch_fault_s fetch_fault,
	input wire logic exc_taken, checkstop,
	input wire logic [19:0] exc_vector,
	input wire logic [31:0] machine_state_reg, save_restore_zero
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rs = hard_reset | soft_reset;
	wire mc = ~bus_transfer_error_n | ~machine_check_pin_n | addr_parity_err | data_parity_err
		| icache_parity_err | dcache_parity_err;
	wire me = machine_state_reg[`EVC_MACHINE_CHECK_ENABLE];
	wire run = ~rs & ~checkstop & ~mc;
	wire dv = run & data_fault.valid;
	wire iv = run & ~data_fault.valid & fetch_fault.valid & |fetch_fault[34:32];
	a_reset_vector: assert property (rs |=> exc_taken && exc_vector == `EVC_VEC_RESET) else $error("reset");
	a_mcheck_vector: assert property (!rs && !checkstop && mc && me |=> exc_taken && exc_vector == `EVC_VEC_MCHECK) else $error("mc");
	a_mcheck_stop: assert property (!rs && !checkstop && mc && !me |=> checkstop && !exc_taken) else $error("stop");
	a_stop_holds: assert property (checkstop && !rs |=> checkstop && !exc_taken) else $error("hold");
	a_enable_cleared: assert property (exc_taken |-> !me) else $error("me");
	a_data_vector: assert property (dv |=> exc_taken && exc_vector == `EVC_VEC_DATA) else $error("data");
	a_data_saved: assert property (dv |=> save_restore_zero == $past(data_fault.next_pc)) else $error("srr");
	a_fetch_vector: assert property (iv |=> exc_taken && exc_vector == `EVC_VEC_INSTR) else $error("fetch");
endmodule : evc_checker
bind evc_exception_unit evc_checker i_evc_checker (.*);

// file: evc_exception_unit.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "evc_map.svh"
module evc_exception_unit
	import evc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             hard_reset,
	input  wire logic             soft_reset,
	input  wire logic             bus_transfer_error_n,
	input  wire logic             machine_check_pin_n,
	input  wire logic             addr_parity_err,
	input  wire logic             data_parity_err,
	input  wire logic             icache_parity_err,
	input  wire logic             dcache_parity_err,
	input  wire logic [31:0]      current_pc,
	input  wire evc_data_fault_s  data_fault,
	input  wire evc_fetch_fault_s fetch_fault,
	input  wire logic             msr_write,
	input  wire logic [31:0]      msr_wdata,
	output logic                  exc_taken,
	output logic [19:0]           exc_vector,
	output logic                  checkstop,
	output logic [31:0]           machine_state_reg,
	output logic [7:0]            data_fault_cause_reg,
	output logic [31:0]           save_restore_zero
);
	// ======================================================
	// state
	evc_state_s q;
	evc_state_s next_q;
	logic       mc_src;
	logic       ifetch_exc;
	logic [7:0] cause;

	// bus error needs no instruction tag: imprecise by design
	assign mc_src = ~bus_transfer_error_n | ~machine_check_pin_n
		| addr_parity_err | data_parity_err | icache_parity_err | dcache_parity_err;
	assign ifetch_exc = fetch_fault.valid & (fetch_fault.xlate_miss
		| fetch_fault.io_segment
		| fetch_fault.read_denied);

	// ======================================================
	// data fault cause bits
	always_comb begin
		cause = 8'h00;
		cause[`EVC_CAUSE_IO]    = data_fault.io_fault;
		cause[`EVC_CAUSE_MISS]  = data_fault.xlate_miss;
		cause[`EVC_CAUSE_PROT]  = data_fault.prot_viol;
		cause[`EVC_CAUSE_SPEC]  = data_fault.seg_io_flag & data_fault.special_op;
		cause[`EVC_CAUSE_STORE] = data_fault.store;
		cause[`EVC_CAUSE_BRK]   = data_fault.brk_match;
		cause[`EVC_CAUSE_SEG]   = data_fault.seg_miss;
		cause[`EVC_CAUSE_EXTD]  = data_fault.ext_op & ~data_fault.ext_enable;
	end

	// ======================================================
	// next state
	always_comb begin
		next_q = q;
		next_q.taken = 1'b0;
		if (msr_write) begin
			next_q.machine_state_reg = msr_wdata;
		end
		unique case (q.mode)
			EVC_RUN: begin
				// fixed priority order
				if (hard_reset | soft_reset) begin
					next_q.taken  = 1'b1;
					next_q.vector = `EVC_VEC_RESET;
				end else if (mc_src) begin
					if (q.machine_state_reg[`EVC_MACHINE_CHECK_ENABLE]) begin
						next_q.taken  = 1'b1;
						next_q.vector = `EVC_VEC_MCHECK;
					end else begin
						next_q.mode = EVC_CHECKSTOP;
					end
				end else if (data_fault.valid) begin
					next_q.taken                = 1'b1;
					next_q.vector               = `EVC_VEC_DATA;
					next_q.data_fault_cause_reg = cause;
				end else if (ifetch_exc) begin
					next_q.taken  = 1'b1;
					next_q.vector = `EVC_VEC_INSTR;
				end
				if (next_q.taken) begin
					next_q.machine_state_reg[`EVC_MACHINE_CHECK_ENABLE] = 1'b0;
					next_q.save_restore_zero = data_fault.valid & ~(hard_reset | soft_reset | mc_src)
						? data_fault.next_pc
						: (ifetch_exc & ~(hard_reset | soft_reset | mc_src) ? fetch_fault.next_pc
						: current_pc);
				end
			end
			EVC_CHECKSTOP: begin
				// only a reset leaves checkstop
				if (hard_reset | soft_reset) begin
					next_q.mode  = EVC_RUN;
					next_q.taken = 1'b1;
					next_q.vector = `EVC_VEC_RESET;
					next_q.machine_state_reg[`EVC_MACHINE_CHECK_ENABLE] = 1'b0;
					next_q.save_restore_zero = current_pc;
				end
			end
			default: next_q.mode = EVC_CHECKSTOP;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q.mode                 <= EVC_RUN;
			q.machine_state_reg    <= `EVC_MSR_RESET;
			q.data_fault_cause_reg <= 8'h00;
			q.save_restore_zero    <= 32'h00000000;
			q.taken                <= 1'b0;
			q.vector               <= 20'h00000;
		end else begin
			q <= next_q;
		end
	end

	assign exc_taken            = q.taken;
	assign exc_vector           = q.vector;
	assign checkstop            = (q.mode == EVC_CHECKSTOP);
	assign machine_state_reg    = q.machine_state_reg;
	assign data_fault_cause_reg = q.data_fault_cause_reg;
	assign save_restore_zero    = q.save_restore_zero;
endmodule : evc_exception_unit

// file: evc_map.svh
`ifndef EVC_MAP_SVH
`define EVC_MAP_SVH
// Notes on behaviour
// - hard or soft reset vectors to 0x00100
// - bus error or pin raises machine check 0x00200
// - enable clear means checkstop, not exception
// - any taken exception clears machine check enable
// - bus or cache parity errors raise machine check
// - bus error machine check is imprecise
// - data access vectors 0x00300, records cause bits
// - io interface fault bit set, else cleared
// - translation miss bit set, else cleared
// - protection violation bit set, else cleared
// - io segment special access bit when flag one
// - direction bit set store, cleared load
// - breakpoint bit on address match, mode active
// - segment lookup fail bit set, else cleared
// - external access disabled bit on external op
// - untranslatable fetch vectors 0x00400
// - fetch from io segment raises instruction access
// - key and protection forbid read, instruction access
// - next instruction address saved in save_restore_zero
`define EVC_VEC_RESET   20'h00100
`define EVC_VEC_MCHECK  20'h00200
`define EVC_VEC_DATA    20'h00300
`define EVC_VEC_INSTR   20'h00400
`define EVC_CAUSE_IO    0
`define EVC_CAUSE_MISS  1
`define EVC_CAUSE_PROT  2
`define EVC_CAUSE_SPEC  3
`define EVC_CAUSE_STORE 4
`define EVC_CAUSE_BRK   5
`define EVC_CAUSE_SEG   6
`define EVC_CAUSE_EXTD  7
`define EVC_MACHINE_CHECK_ENABLE      12
`define EVC_MSR_RESET   32'h00000000
`endif

// file: evc_mem_ctrl.sv
`timescale 1ns/1ps
module evc_mem_ctrl (
	input  wire logic       clk,
	input  wire logic       req,
	input  wire logic       bad,
	input  wire logic [2:0] dly,
	output logic            tea_n
);
	initial tea_n = 1'b1;
	always @(posedge clk) if (req) begin
		repeat (dly) @(posedge clk);
		tea_n <= ~bad;
		@(posedge clk);
		tea_n <= 1'b1;
	end
endmodule : evc_mem_ctrl

// file: evc_pkg.sv
package evc_pkg;
	typedef enum logic [1:0] {EVC_RUN, EVC_CHECKSTOP} evc_mode_e;
	typedef struct packed {
		logic        valid;
		logic        io_fault;
		logic        xlate_miss;
		logic        prot_viol;
		logic        special_op;
		logic        store;
		logic        brk_match;
		logic        seg_miss;
		logic        ext_op;
		logic        ext_enable;
		logic        seg_io_flag;
		logic [31:0] next_pc;
	} evc_data_fault_s;
	typedef struct packed {
		logic        valid;
		logic        xlate_miss;
		logic        io_segment;
		logic        read_denied;
		logic [31:0] next_pc;
	} evc_fetch_fault_s;
	typedef struct packed {
		evc_mode_e   mode;
		logic [31:0] machine_state_reg;
		logic [7:0]  data_fault_cause_reg;
		logic [31:0] save_restore_zero;
		logic        taken;
		logic [19:0] vector;
	} evc_state_s;
endpackage : evc_pkg

// file: tb_evc_exception_unit.sv
`timescale 1ns/1ps
`include "evc_map.svh"
module tb_evc_exception_unit import evc_pkg::*;;
	logic clk = 0, rst = 1, hard_reset = 0, soft_reset = 0, machine_check_pin_n = 1, msr_write = 0, req = 0, bad = 1;
	logic addr_parity_err = 0, data_parity_err = 0, icache_parity_err = 0, dcache_parity_err = 0;
	logic [31:0] current_pc = 0, msr_wdata = 0, rs = 32'h00004281, p, machine_state_reg, save_restore_zero;
	evc_data_fault_s data_fault = '0;
	evc_fetch_fault_s fetch_fault = '0;
	logic exc_taken, checkstop, bus_transfer_error_n;
	logic [19:0] exc_vector, q[$];
	logic [7:0] data_fault_cause_reg, c;
	int err_count = 0, n_tests = 0;
	evc_exception_unit i_evc_exception_unit (.*);
	evc_mem_ctrl i_evc_mem_ctrl (.clk(clk), .req(req), .bad(bad), .dly(rs[2:0]), .tea_n(bus_transfer_error_n));
	function logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xs
	task chk(input logic [31:0] e, input logic [31:0] a);
		n_tests++;
		if (e !== a) begin
			err_count++;
			$display("[FAIL] %0t exp %h got %h", $time, e, a);
		end
	endtask : chk
	task conclude;
		// an expected pulse that never came is a mismatch too
		if (q.size() != 0) err_count++;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task me;
		@(posedge clk);
		msr_write <= 1;
		msr_wdata <= 32'h1 << `EVC_MACHINE_CHECK_ENABLE;
		@(posedge clk);
		msr_write <= 0;
	endtask : me
	// notes the vector (none for 0), holds the staged sources one cycle, then drops them
	task fire(input logic [19:0] v);
		rs = xs(rs);
		current_pc <= rs;
		if (v) q.push_back(v);
		@(posedge clk);
		{hard_reset, soft_reset, addr_parity_err, data_parity_err, icache_parity_err, dcache_parity_err, req} <= '0;
		machine_check_pin_n <= 1;
		data_fault <= '0;
		fetch_fault <= '0;
		repeat (11) @(posedge clk);
	endtask : fire
	always @(posedge clk) if (exc_taken === 1'b1) chk(q.size() ? q.pop_front() : 20'hFFFFF, exc_vector);
	initial forever #2.5 clk = ~clk;
	initial begin
		#20000;
		err_count++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 7; i++) begin
			me();
			@(posedge clk);
			if (i < 4) {dcache_parity_err, icache_parity_err, data_parity_err, addr_parity_err} <= 4'h1 << i;
			else if (i == 4) machine_check_pin_n <= 0;
			else req <= 1;
			fire(`EVC_VEC_MCHECK);
			chk(0, machine_state_reg);
		end
		$display("machine check done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			rs = xs(rs);
			p = rs;
			data_fault <= {1'b1, rs[9:0], rs};
			c = {rs[2] & ~rs[1], rs[3], rs[4], rs[5], rs[6] & rs[0], rs[7], rs[8], rs[9]};
			fire(`EVC_VEC_DATA);
			chk(c, data_fault_cause_reg);
			chk(p, save_restore_zero);
		end
		$display("data access done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			p = rs;
			fetch_fault <= {1'b1, 3'b100 >> i, rs};
			fire(i < 3 ? `EVC_VEC_INSTR : 20'h00000);
			if (i < 3) chk(p, save_restore_zero);
		end
		$display("instruction access done");
		me();
		@(posedge clk);
		{hard_reset, machine_check_pin_n} <= 2'b10;
		data_fault.valid <= 1;
		fire(`EVC_VEC_RESET);
		me();
		@(posedge clk);
		machine_check_pin_n <= 0;
		data_fault.valid <= 1;
		fire(`EVC_VEC_MCHECK);
		@(posedge clk);
		machine_check_pin_n <= 0;
		fire(0);
		@(posedge clk);
		data_fault.valid <= 1;
		fire(0);
		chk(1, checkstop);
		@(posedge clk);
		soft_reset <= 1;
		fire(`EVC_VEC_RESET);
		chk(0, checkstop);
		$display("priority and checkstop done");
		conclude();
	end
endmodule : tb_evc_exception_unit
